// >>> rtl/adc_control_result_regs.sv
// Converter control, trigger, result and pin-disable registers
//
// How it works
// RQ1 - Done interrupt asserted only when enable bit 3 and global enable set.
// RQ2 - Converter clock is system clock over 2,2,4..128 by 3-bit select.
// RQ3 - Right aligned: low byte holds bits 7..0, high bits 1..0 hold 9..8.
// RQ4 - Left aligned: high byte holds bits 9..2, low bits 7..6 hold 1..0.
// RQ5 - A finished conversion loads its 10-bit result into the pair unless held or the low byte is read that cycle.
// RQ6 - Reading low byte freezes both bytes until high byte is read.
// RQ7 - Software may read only the high byte; that read releases the hold.
// RQ8 - Unipolar mode gives 10-bit results, saturating when input is negative.
// RQ9 - Bipolar mode gives two's complement, 9 magnitude bits plus sign.
// RQ10 - Polarity reverse bit swaps the differential pair.
// RQ11 - Control B bits 4 and 3 always read zero.
// RQ12 - Trigger source field ignored while auto triggering is off.
// RQ13 - Auto triggering starts a conversion on each rising selected flag seen while enabled and idle.
// RQ14 - Switching from clear to set source counts as rising edge.
// RQ15 - Switching to free running never makes a trigger event.
// RQ16 - Source codes: free, comparator, ext int 0, cmp A, ovf, cmp B, pin.
// RQ17 - Pin disable bits 5..2 turn off buffers; port bits read zero.
// RQ18 - Done flag set on result update; cleared by vector or writing one.
// RQ19 - Auto trigger enable allows hardware starts on selected edge.
// RQ20 - Alignment change shows at once in the result view.
// RQ21 - Source code 7 gives no trigger events.
//
// Chosen here: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`include "adc_ctrl_map.svh"
module adc_control_result_regs
	import adc_ctrl_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// AXI4-Lite write
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// CPU side
	input wire logic globalIrqEnable,
	input wire logic irqVectorTaken,
	output logic doneIrq,
	// Trigger flags, same clock domain, index is source code
	input wire logic [6:0] triggerFlags,
	// Analog core
	input wire logic [9:0] sampleMagnitude,
	input wire logic sampleNegative,
	output logic coreClockTick,
	output logic polarityReverse,
	output logic bipolarSelect,
	// Port input gating, raw pins are asynchronous
	input wire logic [3:0] analogPinRaw,
	output logic [3:0] analogPinDigital,
	output logic [3:0] analogPinDigitalOff
);

	// ******************************
	// Registers
	// ******************************
	logic [7:0] ctrlA_r;
	logic [7:0] ctrlB_r;
	logic [7:0] pinDis_r;
	logic [7:0] sel_r;
	logic [9:0] result_r;
	logic resultHold_r;
	logic doneFlag_r;
	logic trigSig_r;
	logic firstConv_r;
	logic [4:0] convCount_r;
	conv_state_type state_r;
	conv_state_type state_nxt;
	logic [3:0] pinSync1_r;
	logic [3:0] pinSync2_r;
	logic tick;

	// ******************************
	// Bus handshake
	// ******************************
	logic awHave_r;
	logic wHave_r;
	logic [7:0] awAddr_r;
	logic [31:0] wData_r;
	logic [3:0] wStrb_r;
	logic doWrite;
	logic doRead;
	logic wrMapped;

	assign doWrite = awHave_r && wHave_r && !s_axi_bvalid;
	assign doRead = s_axi_arvalid && s_axi_arready;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			awHave_r <= 1'b0;
			wHave_r <= 1'b0;
			awAddr_r <= 8'h00;
			wData_r <= 32'h0000_0000;
			wStrb_r <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
		end else begin
			s_axi_awready <= !awHave_r && !s_axi_awready;
			s_axi_wready <= !wHave_r && !s_axi_wready;
			if (s_axi_awvalid && s_axi_awready) begin
				awHave_r <= 1'b1;
				awAddr_r <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHave_r <= 1'b1;
				wData_r <= s_axi_wdata;
				wStrb_r <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (doWrite) begin
				awHave_r <= 1'b0;
				wHave_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wrMapped ? `RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ******************************
	// Write decode
	// ******************************
	logic wrCtrlA;
	logic wrCtrlB;
	logic wrPinDis;
	logic wrSel;
	logic [7:0] wByte;

	assign wByte = wData_r[7:0];
	assign wrCtrlA = doWrite && wStrb_r[0] && awAddr_r == 8'(`OFF_CTRL_A);
	assign wrCtrlB = doWrite && wStrb_r[0] && awAddr_r == 8'(`OFF_CTRL_B);
	assign wrPinDis = doWrite && wStrb_r[0] && awAddr_r == 8'(`OFF_PIN_DIS);
	assign wrSel = doWrite && wStrb_r[0] && awAddr_r == 8'(`OFF_SEL);
	assign wrMapped = awAddr_r == 8'(`OFF_CTRL_A)
		|| awAddr_r == 8'(`OFF_RES_LOW) || awAddr_r == 8'(`OFF_RES_HIGH)
		|| awAddr_r == 8'(`OFF_CTRL_B) || awAddr_r == 8'(`OFF_PIN_DIS)
		|| awAddr_r == 8'(`OFF_SEL);

	// ******************************
	// Trigger selection
	// ******************************
	trig_src_type trigSrc;
	logic trigSel;
	logic convEnable;
	logic autoOn;
	logic trigEvent;
	logic toFree;
	logic swStart;
	logic startConv;
	logic busy;

	assign trigSrc = trig_src_type'(ctrlB_r[2:0]);
	assign convEnable = ctrlA_r[`CA_ENABLE];
	assign autoOn = ctrlA_r[`CA_AUTO]; // RQ19
	// Free running reads the done flag; code 7 is tied low
	assign trigSel = (trigSrc == TRIG_FREE) ? doneFlag_r : // RQ16
		(trigSrc == TRIG_NONE) ? 1'b0 : triggerFlags[trigSrc]; // RQ21
	// Edge on the muxed signal, so a source switch can make one
	assign trigEvent = autoOn && trigSel && !trigSig_r; // RQ13 RQ14 RQ12
	// Switch to free running primes the edge memory, so a set flag is no edge
	assign toFree = wrCtrlB && wByte[2:0] == TRIG_FREE; // RQ15
	assign swStart = wrCtrlA && wByte[`CA_START] && wByte[`CA_ENABLE];
	assign busy = state_r != CONV_IDLE;
	assign startConv = !busy && (swStart || (trigEvent && convEnable));

	// ******************************
	// Conversion sequencer
	// ******************************
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			CONV_IDLE: begin
				if (startConv) begin
					state_nxt = CONV_RUN;
				end
			end
			CONV_RUN: begin
				if (!convEnable) begin
					state_nxt = CONV_IDLE;
				end else if (tick && convCount_r == 5'h01) begin
					state_nxt = CONV_DONE;
				end
			end
			CONV_DONE: begin
				state_nxt = CONV_IDLE;
			end
			default: begin
				state_nxt = CONV_IDLE;
			end
		endcase
	end

	// ******************************
	// Result encoding
	// ******************************
	logic [9:0] encoded;

	assign polarityReverse = ctrlB_r[`CB_REVERSE]; // RQ10
	assign bipolarSelect = ctrlB_r[`CB_BIPOLAR];
	// Negative after any reversal already applied by the core
	assign encoded = bipolarSelect ? // RQ9
		(sampleNegative ? 10'((~{1'b0, sampleMagnitude[8:0]}) + 10'h001)
			: {1'b0, sampleMagnitude[8:0]})
		: (sampleNegative ? `FULL_SCALE : sampleMagnitude); // RQ8

	// ******************************
	// Read decode
	// ******************************
	logic [7:0] resLow;
	logic [7:0] resHigh;
	logic [7:0] rdByte;
	logic rdMapped;
	logic rdLow;
	logic rdHigh;
	logic alignLeft;

	assign alignLeft = sel_r[`SEL_ALIGN]; // RQ20
	assign resLow = alignLeft ? {result_r[1:0], 6'h00} // RQ4
		: result_r[7:0]; // RQ3
	assign resHigh = alignLeft ? result_r[9:2] // RQ4
		: {6'h00, result_r[9:8]}; // RQ3
	assign rdLow = doRead && s_axi_araddr == 8'(`OFF_RES_LOW);
	assign rdHigh = doRead && s_axi_araddr == 8'(`OFF_RES_HIGH);
	assign rdMapped = s_axi_araddr == 8'(`OFF_CTRL_A) || rdLow || rdHigh
		|| s_axi_araddr == 8'(`OFF_CTRL_B) || s_axi_araddr == 8'(`OFF_PIN_DIS)
		|| s_axi_araddr == 8'(`OFF_SEL);
	assign rdByte =
		(s_axi_araddr == 8'(`OFF_CTRL_A)) ?
			{ctrlA_r[7], busy, ctrlA_r[5], doneFlag_r, ctrlA_r[3:0]} :
		(s_axi_araddr == 8'(`OFF_RES_LOW)) ? resLow :
		(s_axi_araddr == 8'(`OFF_RES_HIGH)) ? resHigh :
		(s_axi_araddr == 8'(`OFF_CTRL_B)) ? (ctrlB_r & `CTRL_B_MASK) : // RQ11
		(s_axi_araddr == 8'(`OFF_PIN_DIS)) ? pinDis_r :
		(s_axi_araddr == 8'(`OFF_SEL)) ? sel_r : `RESET_BYTE;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `RESP_OKAY;
		end else begin
			// Idle ready never waits on valid, which would deadlock
			s_axi_arready <= !s_axi_rvalid;
			if (doRead) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= {24'h000000, rdByte};
				s_axi_rresp <= rdMapped ? `RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ******************************
	// Control and status state
	// ******************************
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ctrlA_r <= `RESET_BYTE;
			ctrlB_r <= `RESET_BYTE;
			pinDis_r <= `RESET_BYTE;
			sel_r <= `RESET_BYTE;
			state_r <= CONV_IDLE;
			convCount_r <= 5'h00;
			firstConv_r <= 1'b1;
			trigSig_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			trigSig_r <= trigSel || toFree; // RQ15
			if (wrCtrlA) begin
				ctrlA_r <= {wByte[7], 1'b0, wByte[5], 1'b0, wByte[3:0]};
			end
			if (wrCtrlB) begin
				ctrlB_r <= wByte & `CTRL_B_MASK; // RQ11
			end
			if (wrPinDis) begin
				pinDis_r <= wByte & `PIN_DIS_MASK;
			end
			if (wrSel) begin
				sel_r <= wByte;
			end
			if (!convEnable) begin
				firstConv_r <= 1'b1;
			end
			if (startConv) begin
				convCount_r <= firstConv_r ? `FIRST_CYCLES : `CONV_CYCLES;
				firstConv_r <= 1'b0;
			end else if (state_r == CONV_RUN && tick) begin
				convCount_r <= convCount_r - 5'h01;
			end
		end
	end

	// ******************************
	// Result pair, hold and done flag
	// ******************************
	logic loadResult;

	// Frozen result is discarded, as the hold requires
	// A low read in the same cycle freezes the pair as well
	assign loadResult = state_r == CONV_DONE && !resultHold_r // RQ5 RQ6
		&& !rdLow; // RQ6

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			result_r <= 10'h000;
			resultHold_r <= 1'b0;
			doneFlag_r <= 1'b0;
			doneIrq <= 1'b0;
		end else begin
			if (loadResult) begin
				result_r <= encoded; // RQ5
			end
			if (rdHigh) begin
				resultHold_r <= 1'b0; // RQ7
			end else if (rdLow) begin
				resultHold_r <= 1'b1; // RQ6
			end
			// Set wins over either clear
			if (loadResult) begin
				doneFlag_r <= 1'b1; // RQ18
			end else if (irqVectorTaken
				|| (wrCtrlA && wByte[`CA_FLAG])) begin
				doneFlag_r <= 1'b0; // RQ18
			end
			doneIrq <= (doneFlag_r || loadResult) && ctrlA_r[`CA_IRQEN]
				&& globalIrqEnable && !irqVectorTaken; // RQ1
		end
	end

	// ******************************
	// Prescaler and pin buffers
	// ******************************
	clock_divider #(
		.WIDTH(7)
	) u_divider (
		.clock(clock),
		.rst(rst),
		.run(busy),
		.clockDividerSelect(ctrlA_r[2:0]),
		.tick(tick)
	);

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			pinSync1_r <= 4'h0;
			pinSync2_r <= 4'h0;
			analogPinDigital <= 4'h0;
			analogPinDigitalOff <= 4'h0;
			coreClockTick <= 1'b0;
		end else begin
			pinSync1_r <= analogPinRaw;
			pinSync2_r <= pinSync1_r;
			analogPinDigitalOff <= pinDis_r[5:2]; // RQ17
			analogPinDigital <= pinSync2_r & ~pinDis_r[5:2]; // RQ17
			coreClockTick <= tick && busy;
		end
	end

endmodule // adc_control_result_regs

// >>> rtl/clock_divider.sv
// Prescaler that makes the converter clock tick from the system clock
`timescale 1ns/1ps
module clock_divider
	import adc_ctrl_pkg::*;
#(
	parameter int WIDTH = 7
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Control
	input wire logic run,
	input wire logic [2:0] clockDividerSelect,
	// Converter clock tick, one cycle per divided period
	output logic tick
);

	logic [WIDTH-1:0] count_r;
	logic [WIDTH-1:0] limit;
	logic [2:0] shift;

	// Codes 0 and 1 both divide by two
	assign shift = (clockDividerSelect == 3'h0) ? 3'h1 : clockDividerSelect;
	assign limit = WIDTH'((8'h01 << shift) - 8'h01); // RQ2

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			count_r <= '0;
			tick <= 1'b0;
		end else if (!run) begin
			count_r <= '0;
			tick <= 1'b0;
		end else begin
			tick <= (count_r >= limit); // RQ2
			count_r <= (count_r >= limit) ? '0 : count_r + WIDTH'(1);
		end
	end

endmodule // clock_divider

// >>> shared/adc_ctrl_map.svh
// Register offsets, field positions and reset values of the converter control
`ifndef ADC_CTRL_MAP_SVH
`define ADC_CTRL_MAP_SVH

`define OFF_CTRL_A 4'h0
`define OFF_RES_LOW 4'h4
`define OFF_RES_HIGH 4'h8
`define OFF_CTRL_B 4'hC
`define OFF_PIN_DIS 5'h10
`define OFF_SEL 5'h14

`define CA_ENABLE 7
`define CA_START 6
`define CA_AUTO 5
`define CA_FLAG 4
`define CA_IRQEN 3
`define CB_BIPOLAR 7
`define CB_ACME 6
`define CB_REVERSE 5
`define SEL_ALIGN 5

`define RESET_BYTE 8'h00
`define CTRL_B_MASK 8'hE7
`define PIN_DIS_MASK 8'h3C
`define PIN_DIS_LO 2
`define FULL_SCALE 10'h3FF
`define SIGNED_MAX 10'h1FF
`define SIGNED_MIN 10'h200
`define CONV_CYCLES 5'h0D
`define FIRST_CYCLES 5'h19
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// >>> shared/adc_ctrl_pkg.sv
// Types shared by the converter control files
package adc_ctrl_pkg;

	typedef enum logic [2:0] {
		TRIG_FREE = 3'h0,
		TRIG_COMPARATOR = 3'h1,
		TRIG_EXT_INT0 = 3'h2,
		TRIG_TIMER_CMP_A = 3'h3,
		TRIG_TIMER_OVF = 3'h4,
		TRIG_TIMER_CMP_B = 3'h5,
		TRIG_PIN_CHANGE = 3'h6,
		TRIG_NONE = 3'h7
	} trig_src_type;

	typedef enum logic [1:0] {
		CONV_IDLE = 2'h0,
		CONV_RUN = 2'h1,
		CONV_DONE = 2'h2
	} conv_state_type;

endpackage

// >>> sim/adc_control_result_regs_assertions.sv
// Port-level assertion checker for the converter control block
`timescale 1ns/1ps
`include "adc_ctrl_map.svh"
module adc_control_result_regs_checker
	import adc_ctrl_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Register bus
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	// Global interrupt enable and block outputs
	input wire logic globalIrqEnable,
	input wire logic doneIrq,
	input wire logic coreClockTick,
	input wire logic polarityReverse,
	input wire logic bipolarSelect,
	input wire logic [3:0] analogPinDigital,
	input wire logic [3:0] analogPinDigitalOff
);
	// ***********************
	// Shadow of bus traffic
	// ***********************
	logic [7:0] wAddr_r, rAddr_r, wData_r;
	logic wOk_r, alignLeft_r;
	wire commit = s_axi_bvalid && s_axi_bready && wOk_r;
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			wAddr_r <= 8'h00;
			rAddr_r <= 8'h00;
			wData_r <= 8'h00;
			wOk_r <= 1'b0;
			alignLeft_r <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) wAddr_r <= s_axi_awaddr;
			if (s_axi_wvalid && s_axi_wready) wData_r <= s_axi_wdata[7:0];
			if (s_axi_wvalid && s_axi_wready) wOk_r <= s_axi_wstrb[0];
			if (s_axi_arvalid && s_axi_arready) rAddr_r <= s_axi_araddr;
			if (commit && wAddr_r == `OFF_SEL) alignLeft_r <= wData_r[5];
		end
	end
	// ***********************
	// Properties
	// ***********************
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	sequence s_wrCommit;
		s_axi_bvalid && s_axi_bready && wOk_r;
	endsequence
	property p_irqGated;
		doneIrq |-> $past(globalIrqEnable);
	endproperty
	a_irqGated: assert property (p_irqGated) else $error("irq without gie");
	property p_tickGap;
		coreClockTick |=> !coreClockTick;
	endproperty
	a_tickGap: assert property (p_tickGap) else $error("tick too close");
	property p_rightHigh;
		s_axi_rvalid && rAddr_r == `OFF_RES_HIGH && !alignLeft_r
			|-> s_axi_rdata[7:2] == 6'h00;
	endproperty
	a_rightHigh: assert property (p_rightHigh) else $error("high unused");
	property p_leftLow;
		s_axi_rvalid && rAddr_r == `OFF_RES_LOW && alignLeft_r
			|-> s_axi_rdata[5:0] == 6'h00;
	endproperty
	a_leftLow: assert property (p_leftLow) else $error("low unused");
	property p_ctrlBRes;
		s_axi_rvalid && rAddr_r == `OFF_CTRL_B |-> s_axi_rdata[4:3] == 2'h0;
	endproperty
	a_ctrlBRes: assert property (p_ctrlBRes) else $error("ctrl b bits");
	property p_bipolar;
		s_wrCommit ##0 (wAddr_r == `OFF_CTRL_B) |-> bipolarSelect == wData_r[7];
	endproperty
	a_bipolar: assert property (p_bipolar) else $error("bipolar bit");
	property p_reverse;
		s_wrCommit ##0 (wAddr_r == `OFF_CTRL_B)
			|-> polarityReverse == wData_r[5];
	endproperty
	a_reverse: assert property (p_reverse) else $error("reverse bit");
	property p_pinOff;
		s_wrCommit ##0 (wAddr_r == `OFF_PIN_DIS)
			|-> ##[0:1] analogPinDigitalOff == wData_r[5:2];
	endproperty
	a_pinOff: assert property (p_pinOff) else $error("pin off bits");
	property p_pinZero;
		(analogPinDigital & analogPinDigitalOff & $past(analogPinDigitalOff))
			== 4'h0;
	endproperty
	a_pinZero: assert property (p_pinZero) else $error("pin not zero");
endmodule // adc_control_result_regs_checker

bind adc_control_result_regs adc_control_result_regs_checker chk (
	.clock(clock), .rst(rst), .s_axi_awaddr(s_axi_awaddr),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rvalid(s_axi_rvalid), .globalIrqEnable(globalIrqEnable),
	.doneIrq(doneIrq), .coreClockTick(coreClockTick),
	.polarityReverse(polarityReverse), .bipolarSelect(bipolarSelect),
	.analogPinDigital(analogPinDigital),
	.analogPinDigitalOff(analogPinDigitalOff)
);

// >>> sim/tb.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`include "adc_ctrl_map.svh"
module tb;
	logic clock = 1'b0, rst = 1'b1;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h00000000, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hF, analogPinRaw = 4'h0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
	logic s_axi_bready = 1'b1, s_axi_rready = 1'b1, sampleNegative = 1'b0;
	logic globalIrqEnable = 1'b0, irqVectorTaken = 1'b0;
	logic [6:0] triggerFlags = 7'h00;
	logic [9:0] sampleMagnitude = 10'h000, m, v;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, doneIrq, coreClockTick, polarityReverse;
	logic bipolarSelect;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [3:0] analogPinDigital, analogPinDigitalOff;
	int n, i, k, bad_count = 0, cmp_count = 0;
	integer seed = 32'h29d3;
	logic [33:0] eq[$];
	string nq[$];

	adc_control_result_regs dut (
		.clock(clock), .rst(rst), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.globalIrqEnable(globalIrqEnable), .irqVectorTaken(irqVectorTaken),
		.doneIrq(doneIrq), .triggerFlags(triggerFlags),
		.sampleMagnitude(sampleMagnitude), .sampleNegative(sampleNegative),
		.coreClockTick(coreClockTick), .polarityReverse(polarityReverse),
		.bipolarSelect(bipolarSelect), .analogPinRaw(analogPinRaw),
		.analogPinDigital(analogPinDigital),
		.analogPinDigitalOff(analogPinDigitalOff)
	);

	always #20 clock = ~clock;

	// ***********************
	// Checking and closing
	// ***********************
	task check(input string s, input logic [33:0] seen, input logic [33:0] e);
		cmp_count++;
		if (seen !== e) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", s, e, seen);
		end
	endtask
	task test_done();
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// Every wait is bounded so a stuck handshake ends the run
	task guard();
		n++;
		if (n > 2000) begin
			bad_count++;
			test_done();
		end
	endtask
	always @(posedge clock) begin
		if ((s_axi_rvalid && s_axi_rready || s_axi_bvalid && s_axi_bready)
			&& eq.size() > 0) begin
			check(nq.pop_front(), s_axi_rvalid ? {s_axi_rresp, s_axi_rdata}
				: {s_axi_bresp, 32'h00000000}, eq.pop_front());
		end
	end

	// ***********************
	// Bus tasks
	// ***********************
	task wr(input logic [7:0] a, input logic [7:0] d);
		eq.push_back({(a > 8'h14) ? `RESP_SLVERR : `RESP_OKAY,
			32'h00000000});
		nq.push_back("bresp");
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h000000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		n = 0;
		do begin
			@(posedge clock);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			guard();
		end while (s_axi_awvalid && !s_axi_awready ||
			s_axi_wvalid && !s_axi_wready);
		do begin @(posedge clock); guard(); end while (!s_axi_bvalid);
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e, input string s);
		eq.push_back({(a > 8'h14) ? `RESP_SLVERR : `RESP_OKAY, 24'h000000, e});
		nq.push_back(s);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		n = 0;
		do begin @(posedge clock); guard(); end while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do begin @(posedge clock); guard(); end while (!s_axi_rvalid);
	endtask
	task await_done(input logic want, input logic [7:0] clr);
		k = 0;
		while (k < 300 && doneIrq !== 1'b1) begin
			@(posedge clock);
			k++;
		end
		check("done_irq", doneIrq, want);
		if (want && k == 300) test_done();
		if (doneIrq === 1'b1) wr(`OFF_CTRL_A, clr);
	endtask
	// Held conversions may never raise the flag, so wait out 80 cycles
	task conv(input logic ng, input logic hold);
		m = 10'($random(seed)) | 10'h001;
		sampleMagnitude <= m;
		sampleNegative <= ng;
		wr(`OFF_CTRL_A, 8'hC8);
		if (hold) begin
			repeat (80) @(posedge clock);
			wr(`OFF_CTRL_A, 8'h98);
		end else await_done(1'b1, 8'h98);
	endtask

	// ***********************
	// Scenarios
	// ***********************
	initial begin
		repeat (20) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		globalIrqEnable <= 1'b1;
		for (i = 0; i < 7; i++) rd(8'(i * 4), 8'h00, "reset");
		wr(8'h18, 8'hFF);
		wr(`OFF_CTRL_B, 8'hFF);
		rd(`OFF_CTRL_B, 8'hE7, "ctrl_b");
		wr(`OFF_CTRL_B, 8'hA0);
		check("pol_bits", {polarityReverse, bipolarSelect}, 2'h3);
		wr(`OFF_CTRL_B, 8'h00);
		analogPinRaw <= 4'(10'($random(seed))) | 4'h1;
		wr(`OFF_PIN_DIS, 8'hFF);
		repeat (5) @(posedge clock);
		check("pin_off", analogPinDigital, 4'h0);
		check("pin_off_bits", analogPinDigitalOff, 4'hF);
		rd(`OFF_PIN_DIS, 8'h3C, "pin_dis");
		wr(`OFF_PIN_DIS, 8'h00);
		repeat (5) @(posedge clock);
		check("pin_on", analogPinDigital, analogPinRaw);
		$display("registers test done");
		for (i = 0; i < 8; i++) begin
			wr(`OFF_CTRL_A, 8'hC0 | 8'(i));
			n = 0;
			do begin @(posedge clock); guard(); end while (!coreClockTick);
			k = 0;
			do begin @(posedge clock); k++; guard(); end while (!coreClockTick);
			check("divider", k, (i < 2) ? 2 : 1 << i);
			wr(`OFF_CTRL_A, 8'h00);
		end
		$display("divider test done");
		conv(1'b0, 1'b0);
		rd(`OFF_CTRL_A, 8'h88, "flag_clear");
		rd(`OFF_RES_LOW, m[7:0], "right_low");
		v = m;
		conv(1'b0, 1'b1);
		rd(`OFF_RES_HIGH, {6'h00, v[9:8]}, "held_high");
		wr(`OFF_SEL, 8'h20);
		rd(`OFF_RES_HIGH, v[9:2], "left_high");
		rd(`OFF_RES_LOW, {v[1:0], 6'h00}, "left_low");
		rd(`OFF_RES_HIGH, v[9:2], "left_high");
		for (i = 0; i < 2; i++) begin
			conv(1'b0, 1'b0);
			rd(`OFF_RES_HIGH, m[9:2], "high_only");
		end
		wr(`OFF_SEL, 8'h00);
		conv(1'b1, 1'b0);
		rd(`OFF_RES_LOW, 8'hFF, "sat_low");
		rd(`OFF_RES_HIGH, 8'h03, "sat_high");
		wr(`OFF_CTRL_B, 8'h80);
		conv(1'b1, 1'b0);
		v = 10'h000 - {1'b0, m[8:0]};
		rd(`OFF_RES_LOW, v[7:0], "bip_low");
		rd(`OFF_RES_HIGH, {6'h00, v[9:8]}, "bip_high");
		$display("result test done");
		wr(`OFF_CTRL_A, 8'hA8);
		for (i = 1; i < 8; i++) begin
			triggerFlags <= 7'h00;
			wr(`OFF_CTRL_B, 8'(i));
			triggerFlags <= (i < 7) ? 7'(1 << i) : 7'h7E;
			await_done(i < 7, 8'hB8);
		end
		triggerFlags <= 7'h00;
		wr(`OFF_CTRL_A, 8'h88);
		wr(`OFF_CTRL_B, 8'h02);
		triggerFlags <= 7'h04;
		await_done(1'b0, 8'h98);
		wr(`OFF_CTRL_B, 8'h01);
		wr(`OFF_CTRL_A, 8'hA8);
		wr(`OFF_CTRL_B, 8'h02);
		await_done(1'b1, 8'hA0);
		wr(`OFF_CTRL_B, 8'h01);
		wr(`OFF_CTRL_B, 8'h00);
		rd(`OFF_CTRL_A, 8'hB0, "free_switch");
		irqVectorTaken <= 1'b1;
		@(posedge clock);
		irqVectorTaken <= 1'b0;
		rd(`OFF_CTRL_A, 8'hA0, "vector_clear");
		@(posedge clock);
		$display("trigger test done");
		test_done();
	end
endmodule // tb
